//--- fsps_fifo.sv
// Small FIFO between internal RAM reads and flash writes
module fsps_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 4
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [AW:0] count;
	} fsps_fifo_st_t;
	fsps_fifo_st_t s_q;
	fsps_fifo_st_t s_d;
	logic push;
	logic pop;

	////////////////////////////////////////////////////////////////////
	// Flags follow the occupancy count, so full and empty are exact
	assign in_ready = (s_q.count != (AW+1)'(DEPTH));
	assign out_valid = (s_q.count != '0);
	assign out_data = s_q.mem[s_q.rd];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// Next state
	always_comb begin
		s_d = s_q;
		if (push) begin
			s_d.mem[s_q.wr] = in_data;
			s_d.wr = s_q.wr + 1'b1;
		end
		if (pop) begin
			s_d.rd = s_q.rd + 1'b1;
		end
		if (push && !pop) begin
			s_d.count = s_q.count + 1'b1;
		end else if (pop && !push) begin
			s_d.count = s_q.count - 1'b1;
		end
	end

	// Register, pointers cleared on reset
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
endmodule

//--- fsps_flash_model.sv
// Behavioural internal RAM and program flash behind the sequencer
module fsps_flash_model (
	input wire logic mclk,
	input wire logic slow,
	input wire logic ram_rd_en,
	input wire logic [7:0] ram_rd_addr,
	output logic [7:0] ram_rd_data,
	input wire logic flash_wr_en,
	input wire logic [15:0] flash_wr_addr,
	input wire logic [7:0] flash_wr_data,
	output logic flash_wr_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] ram [256];
	logic [7:0] mem [32768];
	int n_wr = 0;
	////////////////////////////////////////////////////////////////////////
	// Read data is good one cycle after a request only; it wobbles otherwise
	// so a sequencer that samples late picks up garbage
	always @(posedge mclk) begin
		ram_rd_data <= ram_rd_en ? ram[ram_rd_addr] : ~ram_rd_data;
		flash_wr_ready <= slow ? ~flash_wr_ready : 1'b1;
		if (flash_wr_en && flash_wr_ready) begin
			mem[flash_wr_addr[14:0]] <= flash_wr_data;
			n_wr <= n_wr + 1;
		end
	end
endmodule

//--- fsps_monitor.sv
// Port-level checker of the flash self-programming sequencer
module fsps_monitor (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	input wire logic ram_rd_en,
	input wire logic flash_wr_en,
	input wire logic [15:0] flash_wr_addr,
	input wire logic [7:0] flash_wr_data,
	input wire logic flash_wr_ready,
	input wire logic fetch_hold,
	input wire logic busy
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	logic cmd_q;
	////////////////////////////////////////////////////////////////////////
	// Marks the data phase of a command write made while idle
	always_ff @(posedge mclk) begin
		cmd_q <= reset_n && hsel && hready && hwrite && !busy &&
			htrans == fsps_pkg::HTRANS_NONSEQ &&
			haddr[9:2] == fsps_pkg::IDX_COMMAND;
	end
	////////////////////////////////////////////////////////////////////////
	a_page_start: assert property (cmd_q &&
		hwdata[7:0] == fsps_pkg::CMD_PAGE |=> busy) else $error("no page start");
	a_byte_start: assert property (cmd_q &&
		hwdata[7:0] == fsps_pkg::CMD_BYTE |=> busy) else $error("no byte start");
	a_read_first: assert property ($rose(busy) |-> ##[0:2] ram_rd_en)
		else $error("no RAM read after start");
	a_wr_hold: assert property (flash_wr_en && !flash_wr_ready |=>
		flash_wr_en && $stable(flash_wr_addr) && $stable(flash_wr_data))
		else $error("flash write dropped or changed");
	a_fetch_busy: assert property (ram_rd_en || flash_wr_en |->
		fetch_hold) else $error("copy traffic without fetch hold");
	a_idle_quiet: assert property (!busy |-> !ram_rd_en && !flash_wr_en)
		else $error("traffic while idle");
	a_busy_end: assert property ($fell(busy) |->
		$past(flash_wr_en && flash_wr_ready)) else $error("early end");
	a_page_bound: assert property (busy && flash_wr_en && flash_wr_ready |=>
		!flash_wr_en || flash_wr_addr[15:6] == $past(flash_wr_addr[15:6]))
		else $error("write left its page");
endmodule

bind fsps_top fsps_monitor fsps_monitor_i (.mclk, .reset_n, .hsel, .haddr,
	.htrans, .hwrite, .hready, .hwdata, .ram_rd_en, .flash_wr_en,
	.flash_wr_addr, .flash_wr_data, .flash_wr_ready, .fetch_hold, .busy);

//--- fsps_pkg.sv
// Package: register map, commands, sizes and states of the flash sequencer
package fsps_pkg;
	// Register indices; the byte address on the bus is the index times four
	localparam logic [7:0] IDX_COMMAND = 8'h94;
	localparam logic [7:0] IDX_ADDR_LOW = 8'h95;
	localparam logic [7:0] IDX_ADDR_HIGH = 8'h96;
	localparam logic [7:0] IDX_RAM_BASE = 8'h97;
	localparam logic [7:0] IDX_STATUS = 8'h98;
	localparam int ADDR_SHIFT = 2;
	localparam logic [7:0] CMD_PAGE = 8'h5a;
	localparam logic [7:0] CMD_BYTE = 8'h1e;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam int PAGE_BYTES = 64;
	localparam int PAGE_COUNT = 512;
	localparam int PAGE_LSB = 6;
	localparam logic [6:0] PAGE_LEN = 7'h40;
	localparam logic [6:0] ONE_LEN = 7'h01;
	localparam int FIFO_DEPTH = 4;
	localparam int FIFO_WIDTH = 24;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	// Sequencer states, Gray coded from IDLE through COPY to DRAIN
	typedef enum logic [1:0] {
		FSPS_IDLE = 2'b00,
		FSPS_COPY = 2'b01,
		FSPS_DRAIN = 2'b11
	} fsps_state_t;
endpackage

//--- fsps_top.sv
// Flash self-programming sequencer with AHB-Lite register slave
//
// Register access over AHB-Lite is this design's own decision.
module fsps_top (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	output logic ram_rd_en,
	output logic [7:0] ram_rd_addr,
	input wire logic [7:0] ram_rd_data,
	output logic flash_wr_en,
	output logic [15:0] flash_wr_addr,
	output logic [7:0] flash_wr_data,
	input wire logic flash_wr_ready,
	output logic fetch_hold,
	output logic busy
);
	typedef struct packed {
		logic [7:0] addr_low;
		logic [7:0] addr_high;
		logic [7:0] ram_base;
		fsps_pkg::fsps_state_t state;
		logic [6:0] issued;
		logic [6:0] written;
		logic [6:0] length;
		logic [15:0] dest;
		logic rd_pend;
		logic [15:0] pend_dest;
		logic dp_write;
		logic [7:0] dp_addr;
		logic [31:0] rdata;
		logic wr_en;
		logic [15:0] wr_addr;
		logic [7:0] wr_data;
		logic last_pg;
	} fsps_st_t;

	fsps_st_t s_q;
	fsps_st_t s_d;
	logic addr_ph;
	logic [7:0] idx;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_out_ready;
	logic [fsps_pkg::FIFO_WIDTH-1:0] fifo_out_data;
	logic [fsps_pkg::FIFO_WIDTH-1:0] fifo_in_data;
	logic issue;
	logic [15:0] flash_base;

	////////////////////////////////////////////////////////////////////
	// Bus decode: zero wait states, always OKAY
	assign addr_ph = hsel && hready && (htrans == fsps_pkg::HTRANS_NONSEQ);
	assign idx = haddr[fsps_pkg::ADDR_SHIFT +: 8];
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = s_q.rdata;

	// Copy engine handshake outputs
	assign busy = (s_q.state != fsps_pkg::FSPS_IDLE);
	assign fetch_hold = busy;
	assign ram_rd_en = issue;
	assign ram_rd_addr = s_q.ram_base + {1'b0, s_q.issued};
	assign flash_wr_en = s_q.wr_en;
	assign flash_wr_addr = s_q.wr_addr;
	assign flash_wr_data = s_q.wr_data;

	// A RAM read is only issued when the FIFO can take the byte, which
	// lets back-pressure from the flash stall reads on the RAM side.
	assign issue = (s_q.state == fsps_pkg::FSPS_COPY) &&
		(s_q.issued != s_q.length) && !s_q.rd_pend && fifo_in_ready;
	assign fifo_in_data = {s_q.pend_dest, ram_rd_data};
	assign fifo_out_ready = !s_q.wr_en || flash_wr_ready;

	// Page base keeps only bits 15..6; byte mode keeps all sixteen
	always_comb begin
		flash_base = {s_q.addr_high, s_q.addr_low};
	end

	////////////////////////////////////////////////////////////////////
	// Next state of registers and sequencer
	always_comb begin
		s_d = s_q;
		// Address phase captured for the data phase
		if (addr_ph) begin
			s_d.dp_write = hwrite && (hsize == fsps_pkg::HSIZE_WORD);
			s_d.dp_addr = idx;
			s_d.rdata = '0;
			if (!hwrite) begin
				case (idx)
					fsps_pkg::IDX_ADDR_LOW: s_d.rdata = {24'h0, s_q.addr_low};
					fsps_pkg::IDX_ADDR_HIGH: s_d.rdata = {24'h0, s_q.addr_high};
					fsps_pkg::IDX_RAM_BASE: s_d.rdata = {24'h0, s_q.ram_base};
					fsps_pkg::IDX_STATUS: s_d.rdata = {30'h0, s_q.last_pg, busy};
					default: s_d.rdata = '0; // Command reads as zero
				endcase
			end
		end else begin
			s_d.dp_write = 1'b0;
		end
		// Data phase writes; configuration frozen while busy
		if (s_q.dp_write && !busy) begin
			case (s_q.dp_addr)
				fsps_pkg::IDX_ADDR_LOW: s_d.addr_low = hwdata[7:0];
				fsps_pkg::IDX_ADDR_HIGH: s_d.addr_high = hwdata[7:0];
				fsps_pkg::IDX_RAM_BASE: s_d.ram_base = hwdata[7:0];
				fsps_pkg::IDX_COMMAND: begin
					if (hwdata[7:0] == fsps_pkg::CMD_PAGE) begin
						s_d.state = fsps_pkg::FSPS_COPY;
						s_d.length = fsps_pkg::PAGE_LEN;
						s_d.dest = {flash_base[15:fsps_pkg::PAGE_LSB],
							6'h00};
						s_d.issued = '0;
						s_d.written = '0;
					end else if (hwdata[7:0] == fsps_pkg::CMD_BYTE) begin
						s_d.state = fsps_pkg::FSPS_COPY;
						s_d.length = fsps_pkg::ONE_LEN;
						s_d.dest = flash_base;
						s_d.issued = '0;
						s_d.written = '0;
					end
					// Reserved codes are ignored
				end
				default: ;
			endcase
		end
		// RAM read returns next cycle; then it enters the FIFO
		s_d.rd_pend = issue;
		if (issue) begin
			s_d.pend_dest = s_q.dest + {9'h0, s_q.issued};
			s_d.issued = s_q.issued + 1'b1;
		end
		// Flash write strobe holds until the array accepts it
		if (s_q.wr_en && flash_wr_ready) begin
			s_d.wr_en = 1'b0;
			s_d.written = s_q.written + 1'b1;
		end
		if (fifo_out_valid && fifo_out_ready) begin
			s_d.wr_en = 1'b1;
			s_d.wr_addr = fifo_out_data[23:8];
			s_d.wr_data = fifo_out_data[7:0];
		end
		// Sequencing: once all reads are out, wait for the writes
		case (s_q.state)
			fsps_pkg::FSPS_IDLE: ;
			fsps_pkg::FSPS_COPY: begin
				if (s_d.issued == s_q.length) begin
					s_d.state = fsps_pkg::FSPS_DRAIN;
				end
			end
			fsps_pkg::FSPS_DRAIN: begin
				if (s_d.written == s_q.length) begin
					s_d.state = fsps_pkg::FSPS_IDLE;
					s_d.last_pg = (s_q.length == fsps_pkg::PAGE_LEN);
				end
			end
			default: s_d.state = fsps_pkg::FSPS_IDLE;
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// State register with synchronous reset
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			s_q <= '0;
			s_q.state <= fsps_pkg::FSPS_IDLE;
			s_q.addr_low <= fsps_pkg::RESET_BYTE;
			s_q.addr_high <= fsps_pkg::RESET_BYTE;
			s_q.ram_base <= fsps_pkg::RESET_BYTE;
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Buffer between RAM reads and flash writes
	fsps_fifo #(
		.WIDTH(fsps_pkg::FIFO_WIDTH),
		.DEPTH(fsps_pkg::FIFO_DEPTH)
	) u_fifo (
		.mclk(mclk),
		.reset_n(reset_n),
		.in_valid(s_q.rd_pend),
		.in_ready(fifo_in_ready),
		.in_data(fifo_in_data),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out_data)
	);
endmodule

//--- fsps_top_tb.sv
// Register-level tests of the flash self-programming sequencer
module fsps_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 0, reset_n = 0, hsel = 1, hwrite = 0, slow = 0, hready;
	logic [31:0] haddr = 0, hwdata = 0, q, hrdata;
	logic [1:0] htrans = 0;
	logic [2:0] hsize = fsps_pkg::HSIZE_WORD;
	logic hreadyout, hresp, ram_rd_en, flash_wr_en, flash_wr_ready;
	logic fetch_hold, busy;
	logic [7:0] ram_rd_addr, ram_rd_data, flash_wr_data;
	logic [15:0] flash_wr_addr;
	int n_fail = 0, checks = 0;
	assign hready = hreadyout;
	always #5 mclk = ~mclk;
	fsps_top fsps_top_i (.mclk, .reset_n, .hsel, .haddr, .htrans, .hwrite,
		.hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .ram_rd_en,
		.ram_rd_addr, .ram_rd_data, .flash_wr_en, .flash_wr_addr,
		.flash_wr_data, .flash_wr_ready, .fetch_hold, .busy);
	fsps_flash_model m (.mclk, .slow, .ram_rd_en, .ram_rd_addr, .ram_rd_data,
		.flash_wr_en, .flash_wr_addr, .flash_wr_data, .flash_wr_ready);
	////////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] rv(input logic [7:0] a);
		return a ^ 8'h5c;
	endfunction
	task automatic cmp(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// One AHB-Lite single transfer; read data lands in q
	task automatic xfer(input logic w, input logic [7:0] i,
		input logic [31:0] d);
		haddr <= {22'h0, i, 2'h0};
		htrans <= fsps_pkg::HTRANS_NONSEQ;
		hwrite <= w;
		do @(posedge mclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge mclk); while (hready !== 1'b1);
		q = hrdata;
		cmp({31'h0, hresp}, 32'h0);
	endtask
	// Two quiet cycles after a command, then poll busy with a bound;
	// the first poll always runs, as q still holds the value read back by the last transfer before the call
	task automatic wait_idle;
		int n = 0;
		repeat (2) @(posedge mclk);
		do begin
			xfer(0, fsps_pkg::IDX_STATUS, 0);
			n++;
		end while (q[0] !== 1'b0 && n < 3000);
		if (q[0] !== 1'b0) n_fail++; // Poll limit ran out
	endtask
	task automatic tally_and_finish;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	// Watchdog at 10000 cycles; the whole run needs well under that
	initial begin
		#100us;
		n_fail++;
		tally_and_finish;
	end
	initial begin
		for (int i = 0; i < 256; i++) m.ram[i] = rv(8'(i));
		for (int i = 0; i < 32768; i++) m.mem[i] = 8'hff;
		repeat (10) @(posedge mclk);
		reset_n <= 1;
		@(posedge mclk);
		// Reset values; command and unmapped places read zero
		for (int i = 0; i < 6; i++) begin
			xfer(0, fsps_pkg::IDX_COMMAND + 8'(i), 0);
			cmp(q, 0);
		end
		// Byte program from RAM 0x60 to flash 0x1fc5
		xfer(1, fsps_pkg::IDX_ADDR_LOW, 'hc5);
		xfer(1, fsps_pkg::IDX_ADDR_HIGH, 'h1f);
		xfer(1, fsps_pkg::IDX_RAM_BASE, 'h60);
		xfer(0, fsps_pkg::IDX_ADDR_HIGH, 0);
		cmp(q, 'h1f);
		xfer(0, fsps_pkg::IDX_RAM_BASE, 0);
		cmp(q, 'h60);
		// Only a defined code; no system watchdog runs in this bench
		xfer(1, fsps_pkg::IDX_COMMAND, fsps_pkg::CMD_BYTE);
		wait_idle;
		cmp(m.mem[15'h1fc5], rv(8'h60));
		cmp(m.mem[15'h1fc6], 'hff);
		cmp(m.n_wr, 1);
		// A reserved code starts nothing
		xfer(1, fsps_pkg::IDX_COMMAND, 'h33);
		xfer(0, fsps_pkg::IDX_STATUS, 0);
		cmp(q, 0);
		// Page 510 with offset bits set, wrapping base, stalling flash;
		// the last byte of page 509 and the first byte of page 511 stay untouched
		slow <= 1;
		xfer(1, fsps_pkg::IDX_ADDR_LOW, 'h95);
		xfer(1, fsps_pkg::IDX_ADDR_HIGH, 'h7f);
		xfer(1, fsps_pkg::IDX_RAM_BASE, 'hf0);
		xfer(1, fsps_pkg::IDX_COMMAND, fsps_pkg::CMD_PAGE);
		xfer(1, fsps_pkg::IDX_RAM_BASE, 'h00);
		xfer(0, fsps_pkg::IDX_STATUS, 0);
		cmp(q[0], 1);
		xfer(0, fsps_pkg::IDX_RAM_BASE, 0);
		cmp(q, 'hf0);
		wait_idle;
		for (int i = 0; i < 64; i++)
			cmp(m.mem[15'h7f80 + 15'(i)], rv(8'hf0 + 8'(i)));
		cmp(m.mem[15'h7f7f], 'hff);
		cmp(m.mem[15'h7fc0], 'hff);
		cmp(m.n_wr, 65);
		xfer(0, fsps_pkg::IDX_STATUS, 0);
		cmp(q, 'h2);
		tally_and_finish;
	end
endmodule
